// File: core/sfx_exec_unit.v
// Execution unit for shift, flag copy, flag set/clear, loads and stores
`timescale 1ns/1ns
`include "sfx_map.vh"
module sfx_exec_unit #(
  parameter REG_COUNT = 32,
  parameter IDX_WIDTH = 5
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 reset_n,
  // Command port
  input  wire                 opValid,
  input  wire [3:0]           opCode,
  input  wire [IDX_WIDTH-1:0] opReg,
  input  wire [2:0]           opBit,
  input  wire [1:0]           opPtr,
  input  wire [1:0]           opMode,
  input  wire [5:0]           opDisp,
  input  wire [15:0]          opAddr,
  output reg                  busy,
  output reg                  done,
  // Register file preload and observation
  input  wire                 regWrEn,
  input  wire [IDX_WIDTH-1:0] regWrIdx,
  input  wire [7:0]           regWrData,
  input  wire [IDX_WIDTH-1:0] regRdIdx,
  output reg  [7:0]           regRdData,
  // Status flags
  output reg  [7:0]           statusFlags,
  // Data memory
  output reg  [15:0]          memAddr,
  output reg                  memRead,
  output reg                  memWrite,
  output reg  [7:0]           memWrData,
  input  wire [7:0]           memRdData
);

  ////////////////////////////////////////////////////////////////////////////
  // State and storage

  localparam ST_IDLE = 1'b0;
  localparam ST_MEM  = 1'b1;

  reg [7:0]           regFile [0:REG_COUNT-1];
  reg                 state;
  reg                 pendLoad;
  reg [IDX_WIDTH-1:0] pendDest;
  integer             i;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Low register index of a pointer pair; the unused code maps to the third
  function [IDX_WIDTH-1:0] ptrIndex;
    input [1:0] sel;
    begin
      if (sel == 2'h3) begin
        ptrIndex = `SFX_PTR_BASE_INDEX + {2'h0, `SFX_PTR_THIRD, 1'b0};
      end else begin
        ptrIndex = `SFX_PTR_BASE_INDEX + {2'h0, sel, 1'b0};
      end
    end
  endfunction

  // Full 16-bit step so carry and borrow cross the byte boundary
  function [15:0] step16;
    input [15:0] value;
    input        down;
    begin
      if (down) begin
        step16 = value - 16'h0001;
      end else begin
        step16 = value + 16'h0001;
      end
    end
  endfunction

  // Loads write their destination at the second edge
  function isLoadCmd;
    input [3:0] code;
    begin
      isLoadCmd = (code == `SFX_OP_MEMORY_READ) ||
                  (code == `SFX_OP_READ_ABSOLUTE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and address generation

  wire [IDX_WIDTH-1:0] ptrLowIdx;
  wire [IDX_WIDTH-1:0] ptrHighIdx;
  wire [15:0]          ptrValue;
  wire [7:0]           srcByte;
  wire                 dispAllowed;

  assign ptrLowIdx   = ptrIndex(opPtr);
  assign ptrHighIdx  = ptrLowIdx + 5'h01;
  assign ptrValue    = {regFile[ptrHighIdx], regFile[ptrLowIdx]};
  assign srcByte     = regFile[opReg];
  // Only the second and third pairs take a displacement
  assign dispAllowed = (opPtr != `SFX_PTR_FIRST);

  reg [15:0] next_addr;
  reg [15:0] next_ptr;
  reg        ptrUpdate;

  always @* begin
    next_addr = ptrValue;
    next_ptr  = ptrValue;
    ptrUpdate = 1'b0;
    case (opMode)
      `SFX_MODE_POST_INC: begin
        next_addr = ptrValue;
        next_ptr  = step16(ptrValue, 1'b0);
        ptrUpdate = 1'b1;
      end
      `SFX_MODE_PRE_DEC: begin
        next_ptr  = step16(ptrValue, 1'b1);
        next_addr = next_ptr;
        ptrUpdate = 1'b1;
      end
      `SFX_MODE_DISPLACE: begin
        if (dispAllowed) begin
          next_addr = ptrValue + {10'h000, opDisp};
        end
      end
      default: begin
        next_addr = ptrValue;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter

  wire [7:0] shiftResult;
  wire       shiftC;
  wire       shiftZ;
  wire       shiftN;
  wire       shiftV;

  sfx_shift_unit u_shift (
    .operand (srcByte),
    .carryIn (statusFlags[`SFX_FLAG_C]),
    .arith   (opCode == `SFX_OP_ARITH_SHIFT_RIGHT),
    .result  (shiftResult),
    .flagC   (shiftC),
    .flagZ   (shiftZ),
    .flagN   (shiftN),
    .flagV   (shiftV)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag update

  reg [7:0] next_flags;

  // Single writer, so a raise and a lower never meet in one cycle
  always @* begin
    next_flags = statusFlags;
    case (opCode)
      `SFX_OP_ROTATE_RIGHT_CARRY,
      `SFX_OP_ARITH_SHIFT_RIGHT: begin
        next_flags[`SFX_FLAG_C] = shiftC;
        next_flags[`SFX_FLAG_Z] = shiftZ;
        next_flags[`SFX_FLAG_N] = shiftN;
        next_flags[`SFX_FLAG_V] = shiftV;
      end
      `SFX_OP_BIT_COPY_TO_FLAG: begin
        next_flags[`SFX_FLAG_T] = srcByte[opBit];
      end
      `SFX_OP_FLAG_RAISE: begin
        next_flags[opBit] = 1'b1;
      end
      `SFX_OP_FLAG_LOWER: begin
        next_flags[opBit] = 1'b0;
      end
      default: begin
        // Copy to bit and memory commands keep every flag
        next_flags = statusFlags;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Observation port

  // Registered, so it shows the value from before a write at the same edge
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regFile[regRdIdx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      for (i = 0; i < REG_COUNT; i = i + 1) begin
        regFile[i] <= `SFX_REG_RESET;
      end
      state       <= ST_IDLE;
      busy        <= 1'b0;
      done        <= 1'b0;
      pendLoad    <= 1'b0;
      pendDest    <= {IDX_WIDTH{1'b0}};
      statusFlags <= `SFX_FLAGS_RESET;
      memAddr     <= 16'h0000;
      memRead     <= 1'b0;
      memWrite    <= 1'b0;
      memWrData   <= 8'h00;
    end else begin
      done      <= 1'b0;
      memRead   <= 1'b0;
      memWrite  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (opValid) begin
            statusFlags <= next_flags;
            case (opCode)
              `SFX_OP_ROTATE_RIGHT_CARRY,
              `SFX_OP_ARITH_SHIFT_RIGHT: begin
                regFile[opReg] <= shiftResult;
                done <= 1'b1;
              end
              `SFX_OP_BIT_COPY_TO_FLAG: begin
                done <= 1'b1;
              end
              `SFX_OP_FLAG_COPY_TO_BIT: begin
                regFile[opReg][opBit] <= statusFlags[`SFX_FLAG_T];
                done <= 1'b1;
              end
              `SFX_OP_FLAG_RAISE: begin
                done <= 1'b1;
              end
              `SFX_OP_FLAG_LOWER: begin
                done <= 1'b1;
              end
              `SFX_OP_MEMORY_READ: begin
                memAddr  <= next_addr;
                memRead  <= 1'b1;
                pendLoad <= isLoadCmd(opCode);
                pendDest <= opReg;
                busy     <= 1'b1;
                state    <= ST_MEM;
                if (ptrUpdate) begin
                  regFile[ptrLowIdx]  <= next_ptr[7:0];
                  regFile[ptrHighIdx] <= next_ptr[15:8];
                end
              end
              `SFX_OP_MEMORY_WRITE: begin
                memAddr   <= next_addr;
                memWrData <= srcByte;
                memWrite  <= 1'b1;
                pendLoad  <= 1'b0;
                busy      <= 1'b1;
                state     <= ST_MEM;
                if (ptrUpdate) begin
                  regFile[ptrLowIdx]  <= next_ptr[7:0];
                  regFile[ptrHighIdx] <= next_ptr[15:8];
                end
              end
              `SFX_OP_READ_ABSOLUTE: begin
                memAddr  <= opAddr;
                memRead  <= 1'b1;
                pendLoad <= isLoadCmd(opCode);
                pendDest <= opReg;
                busy     <= 1'b1;
                state    <= ST_MEM;
              end
              `SFX_OP_WRITE_ABSOLUTE: begin
                memAddr   <= opAddr;
                memWrData <= srcByte;
                memWrite  <= 1'b1;
                pendLoad  <= 1'b0;
                busy      <= 1'b1;
                state     <= ST_MEM;
              end
              default: begin
                // Unknown codes retire with no effect
                done <= 1'b1;
              end
            endcase
          end else if (regWrEn) begin
            regFile[regWrIdx] <= regWrData;
          end
        end
        ST_MEM: begin
          // Second cycle; memory answers while memRead is high
          if (pendLoad) begin
            regFile[pendDest] <= memRdData;
          end
          pendLoad <= 1'b0;
          busy     <= 1'b0;
          done     <= 1'b1;
          state    <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule // sfx_exec_unit

// File: core/sfx_map.vh
// Constants for the shift, flag and load/store execution unit
//
// Operation
// - Rotate right through carry puts old carry in bit 7, shifts down, old bit 0 to carry, sets Z,C,N,V in one cycle.
// - Arithmetic shift right moves bits 7..1 to 6..0, keeps bit 7, sets Z,C,N,V in one cycle.
// - Bit copy to flag puts the chosen source bit into the transfer flag in one cycle, nothing else changes.
// - Flag copy to bit puts the transfer flag into the chosen destination bit in one cycle, flags unchanged.
// - Single-cycle raise and lower of the half-carry flag touch only that flag.
// - Single-cycle raise and lower of the overflow flag touch only that flag.
// - Single-cycle raise and lower of the sign flag touch only it; carry, negative and zero have the same.
// - Indirect read loads the byte at the pointer, then post-increment adds one; two cycles, no flags.
// - Pre-decrement read first subtracts one from the pointer, then loads; two cycles, no flags.
// - Displaced read loads from the second or third pointer plus offset, pointer kept; two cycles, no flags.
// - Absolute read loads the byte at the address in the command; two cycles, no flags.
// - Indirect write stores at the pointer, then post-increment adds one; two cycles, no flags.
// - Pre-decrement write first subtracts one from the pointer, then stores; two cycles, no flags.
// - Displaced write stores at the second or third pointer plus offset, pointer kept; two cycles, no flags.
`ifndef SFX_MAP_VH
`define SFX_MAP_VH

// Command codes
`define SFX_OP_ROTATE_RIGHT_CARRY 4'h0
`define SFX_OP_ARITH_SHIFT_RIGHT  4'h1
`define SFX_OP_BIT_COPY_TO_FLAG   4'h2
`define SFX_OP_FLAG_COPY_TO_BIT   4'h3
`define SFX_OP_FLAG_RAISE         4'h4
`define SFX_OP_FLAG_LOWER         4'h5
`define SFX_OP_MEMORY_READ        4'h6
`define SFX_OP_MEMORY_WRITE       4'h7
`define SFX_OP_READ_ABSOLUTE      4'h8
`define SFX_OP_WRITE_ABSOLUTE     4'h9

// Addressing modes of indirect access
`define SFX_MODE_PLAIN    2'h0
`define SFX_MODE_POST_INC 2'h1
`define SFX_MODE_PRE_DEC  2'h2
`define SFX_MODE_DISPLACE 2'h3

// Pointer pair select
`define SFX_PTR_FIRST  2'h0
`define SFX_PTR_SECOND 2'h1
`define SFX_PTR_THIRD  2'h2

// Low register index of the first pointer pair
`define SFX_PTR_BASE_INDEX 5'h1A

// Status flag bit positions
`define SFX_FLAG_C 3'h0
`define SFX_FLAG_Z 3'h1
`define SFX_FLAG_N 3'h2
`define SFX_FLAG_V 3'h3
`define SFX_FLAG_S 3'h4
`define SFX_FLAG_H 3'h5
`define SFX_FLAG_T 3'h6
`define SFX_FLAG_I 3'h7

// Reset values
`define SFX_FLAGS_RESET 8'h00
`define SFX_REG_RESET   8'h00

`endif

// File: core/sfx_shift_unit.v
// Right rotate and arithmetic right shift with flag results
`timescale 1ns/1ns
module sfx_shift_unit (
  // Operand
  input  wire [7:0] operand,
  input  wire       carryIn,
  input  wire       arith,
  // Result
  output wire [7:0] result,
  output wire       flagC,
  output wire       flagZ,
  output wire       flagN,
  output wire       flagV
);

  wire topBit;

  // Arithmetic shift keeps the sign, rotate brings carry in
  assign topBit = arith ? operand[7] : carryIn;
  assign result = {topBit, operand[7:1]};
  assign flagC  = operand[0];
  assign flagZ  = (result == 8'h00);
  assign flagN  = result[7];
  // Overflow is N xor C after the shift
  assign flagV  = result[7] ^ operand[0];

endmodule // sfx_shift_unit

// File: verif/sfx_exec_checker.sv
// Port assertions for the execution unit
`timescale 1ns/1ns
module sfx_exec_checker (
  // Clock and reset
  input wire       clk_sys,
  input wire       reset_n,
  // Command port
  input wire       opValid,
  input wire [3:0] opCode,
  input wire [2:0] opBit,
  input wire       busy,
  input wire       done,
  // Flags and memory strobes
  input wire [7:0] statusFlags,
  input wire       memRead,
  input wire       memWrite
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire go    = opValid && !busy;
  wire goMem = go && opCode >= 4'h6 && opCode <= 4'h9;
  ////////////////////////////////////////////////////////////////////////////
  a_single_done: assert property (go && opCode < 4'h6 |=> done && !busy)
    else $error("single-cycle command did not retire");
  a_mem_two_cycle: assert property (
    goMem |=> busy && !done ##1 done && !busy)
    else $error("memory command did not take two cycles");
  a_mem_no_flags: assert property (goMem |=> $stable(statusFlags) [*2])
    else $error("memory command changed a flag");
  a_strobe_pulse: assert property (
    memRead || memWrite |=> done && !memRead && !memWrite)
    else $error("memory strobe longer than one cycle");
  a_copy_flag: assert property (
    go && opCode == 4'h2 |=> statusFlags[5:0] == $past(statusFlags[5:0])
      && statusFlags[7] == $past(statusFlags[7]))
    else $error("bit copy touched another flag");
  a_copy_bit: assert property (go && opCode == 4'h3 |=> $stable(statusFlags))
    else $error("flag copy to bit changed flags");
  a_flag_raise: assert property (
    go && opCode == 4'h4 |=>
      statusFlags == ($past(statusFlags) | (8'h01 << $past(opBit))))
    else $error("flag raise wrong");
  a_flag_lower: assert property (
    go && opCode == 4'h5 |=>
      statusFlags == ($past(statusFlags) & ~(8'h01 << $past(opBit))))
    else $error("flag lower wrong");
  a_shift_vflag: assert property (
    go && opCode < 4'h2 |=> statusFlags[3] == (statusFlags[2] ^ statusFlags[0])
      && statusFlags[7:4] == $past(statusFlags[7:4]))
    else $error("shift flags wrong");
endmodule // sfx_exec_checker

bind sfx_exec_unit sfx_exec_checker u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .opValid(opValid), .opCode(opCode), .opBit(opBit),
  .busy(busy), .done(done), .statusFlags(statusFlags),
  .memRead(memRead), .memWrite(memWrite));

// File: verif/test_shift_flag_load_store_exec.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ns
module test_shift_flag_load_store_exec;
  reg         clk_sys, reset_n, opValid, regWrEn;
  reg  [3:0]  opCode;
  reg  [4:0]  opReg, regWrIdx, regRdIdx;
  reg  [2:0]  opBit;
  reg  [1:0]  opPtr, opMode;
  reg  [5:0]  opDisp;
  reg  [15:0] opAddr;
  reg  [7:0]  regWrData, fl;
  reg  [7:0]  m [0:31];
  reg  [31:0] lf;
  wire        busy, done, memRead, memWrite;
  wire [7:0]  regRdData, statusFlags, memWrData, memRdData;
  wire [15:0] memAddr;
  integer     n_fail, samples_checked, i, n;
  integer     cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  sfx_exec_unit u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .opValid(opValid), .opCode(opCode), .opReg(opReg), .opBit(opBit),
    .opPtr(opPtr), .opMode(opMode), .opDisp(opDisp), .opAddr(opAddr),
    .busy(busy), .done(done), .regWrEn(regWrEn), .regWrIdx(regWrIdx),
    .regWrData(regWrData), .regRdIdx(regRdIdx), .regRdData(regRdData),
    .statusFlags(statusFlags), .memAddr(memAddr), .memRead(memRead),
    .memWrite(memWrite), .memWrData(memWrData), .memRdData(memRdData));
  // Memory content derived from address, so no storage is needed
  function [7:0] mf(input [15:0] a);
    mf = a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  assign memRdData = mf(memAddr);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [4:0] idx, input [7:0] d);
    begin
      {opValid, regWrEn} = 2'b01;
      regWrIdx = idx;
      regWrData = d;
      m[idx] = d;
      @(negedge clk_sys);
    end
  endtask
  task rchk(input [4:0] idx);
    begin
      {opValid, regWrEn} = 2'b00;
      regRdIdx = idx;
      @(negedge clk_sys);
      chk(regRdData, m[idx]);
    end
  endtask
  task cmd(input [3:0] c, input [4:0] r, input [2:0] b, input [1:0] p,
           input [1:0] md, input [5:0] q, input [15:0] ad);
    reg [4:0]  lo;
    reg [15:0] pv, a;
    reg [7:0]  v, sv;
    begin
      {opValid, regWrEn} = 2'b10;
      {opCode, opReg, opBit, opPtr, opMode, opDisp, opAddr} =
        {c, r, b, p, md, q, ad};
      lo = 5'h1A + {2'h0, p, 1'b0};
      pv = {m[lo+1], m[lo]};
      v = m[r];
      sv = v;
      a = ad;
      if (c < 2) begin
        v = c[0] ? {v[7], v[7:1]} : {fl[0], v[7:1]};
        fl[3:0] = {v[7] ^ sv[0], v[7], v == 8'h00, sv[0]};
        m[r] = v;
      end
      if (c == 2) fl[6] = v[b];
      if (c == 3) m[r][b] = fl[6];
      if (c == 4) fl[b] = 1'b1;
      if (c == 5) fl[b] = 1'b0;
      if (c == 6 || c == 7) begin
        if (md == 2) pv = pv - 16'h0001;
        a = (md == 3 && p != 0) ? pv + q : pv;
        if (md == 1) pv = pv + 16'h0001;
        {m[lo+1], m[lo]} = pv;
      end
      if (c == 6 || c == 8) m[r] = mf(a);
      @(negedge clk_sys);
      if (c > 5 && c < 10) begin
        // Raise during busy must be ignored
        opCode = 4'h4;
        chk({busy, done}, 2'h2);
        chk(memAddr, a);
        chk(memWrData & {8{c[0]}}, sv & {8{c[0]}});
        chk({memRead, memWrite}, {~c[0], c[0]});
        @(negedge clk_sys);
      end
      chk({busy, done}, 2'h1);
      chk(statusFlags, fl);
    end
  endtask
  task ptrs;
    for (i = 26; i < 32; i = i + 1) rchk(i[4:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  initial begin
    {opValid, regWrEn, opCode, opReg, opBit, opPtr, opMode} = 0;
    {opDisp, opAddr, regWrIdx, regWrData, regRdIdx} = 0;
    {reset_n, n_fail, samples_checked, fl, lf} = {1'b0, 64'h0, 8'h0, 32'd97552};
    for (i = 0; i < 32; i = i + 1) m[i] = 8'h00;
    repeat (16) @(negedge clk_sys);
    reset_n = 1;
    for (n = 0; n < 32; n = n + 1) rchk(n[4:0]);
    chk(statusFlags, 16'h0000);
    $display("test reset done");
    // Pointer stepping across byte boundaries and wrap
    wreg(5'h1A, 8'hFF);
    wreg(5'h06, 8'h3C);
    cmd(4'h6, 5'h05, 3'h0, 2'h0, 2'h1, 6'h00, 16'h0000);
    cmd(4'h7, 5'h06, 3'h0, 2'h1, 2'h2, 6'h00, 16'h0000);
    cmd(4'h6, 5'h07, 3'h0, 2'h1, 2'h2, 6'h00, 16'h0000);
    cmd(4'h7, 5'h06, 3'h0, 2'h1, 2'h3, 6'h3F, 16'h0000);
    cmd(4'h6, 5'h09, 3'h0, 2'h2, 2'h3, 6'h3F, 16'h0000);
    cmd(4'h7, 5'h06, 3'h0, 2'h2, 2'h1, 6'h00, 16'h0000);
    cmd(4'h9, 5'h06, 3'h0, 2'h0, 2'h0, 6'h00, 16'hFFFF);
    cmd(4'h8, 5'h04, 3'h0, 2'h0, 2'h0, 6'h00, 16'h8001);
    ptrs;
    $display("test pointers done");
    // Shift corners: zero result, carry into top bit, sign kept
    wreg(5'h03, 8'h01);
    wreg(5'h04, 8'h81);
    cmd(4'h0, 5'h03, 3'h0, 2'h0, 2'h0, 6'h00, 16'h0000);
    cmd(4'h0, 5'h03, 3'h0, 2'h0, 2'h0, 6'h00, 16'h0000);
    cmd(4'h1, 5'h04, 3'h0, 2'h0, 2'h0, 6'h00, 16'h0000);
    cmd(4'h2, 5'h04, 3'h7, 2'h0, 2'h0, 6'h00, 16'h0000);
    cmd(4'h3, 5'h02, 3'h5, 2'h0, 2'h0, 6'h00, 16'h0000);
    for (n = 0; n < 16; n = n + 1)
      cmd({3'h2, n[3]}, 5'h00, n[2:0], 2'h0, 2'h0, 6'h00, 16'h0000);
    cmd(4'hF, 5'h03, 3'h2, 2'h0, 2'h0, 6'h00, 16'h0000);
    for (n = 0; n < 5; n = n + 1) rchk(n[4:0]);
    $display("test shifts and flags done");
    for (n = 0; n < 300; n = n + 1) begin
      lf = nx(lf);
      if (lf[3]) wreg(lf[8:4], lf[16:9]);
      cmd(lf[20:17] % 4'hA, lf[25:21], lf[28:26], lf[30:29] % 2'h3,
          lf[12:11], lf[18:13], lf[31:16]);
      rchk(lf[25:21]);
      if (lf[20:17] % 4'hA > 4'h5) ptrs;
    end
    $display("test random done");
    print_verdict;
  end
endmodule // test_shift_flag_load_store_exec
